// ==== rtl/atw_map.svh ====
`ifndef ATW_MAP_SVH
`define ATW_MAP_SVH

// ****************************************************************
// Clock rate and link timing
// ****************************************************************
`define ATW_CLK_MHZ          125
`define ATW_POWERUP_MS       350
`define ATW_SLEEP_HOLD_US    100
`define ATW_SKEW_US          2
`define ATW_SCLK_HALF        8

// ****************************************************************
// Data word layout and special codes
// ****************************************************************
`define ATW_WORD_BITS        24
`define ATW_WORD_LAST        5'h17
`define ATW_CAL_EXTRA        2'h2
`define ATW_POLL_EXTRA       2'h1
`define ATW_POS_FULL         24'h7f_ffff
`define ATW_NEG_FULL         24'h80_0000
`define ATW_ZERO_WORD        24'h00_0000

`endif

// ==== rtl/atw_pkg.sv ====
package atw_pkg;

    typedef enum logic [2:0] {
        ATW_ST_POWERUP    = 3'b000,
        ATW_ST_WAIT_LOW   = 3'b001,
        ATW_ST_SKEW       = 3'b010,
        ATW_ST_SHIFT      = 3'b011,
        ATW_ST_EXTRA      = 3'b100,
        ATW_ST_SLEEP_HOLD = 3'b101,
        ATW_ST_SLEEP      = 3'b110
    } atw_state_type;

endpackage

// ==== rtl/atw_sync2.sv ====
`timescale 1ns/100ps

module atw_sync2 (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);

    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = d;
        sync_d = meta_q;
    end

    // The idle level of the ready line is high, so both stages reset high.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q = sync_q;

endmodule

// ==== rtl/atw_sclk_pulse.sv ====
`timescale 1ns/100ps
`include "atw_map.svh"

module atw_sclk_pulse (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    output logic      sclk,
    output logic      busy,
    output logic      sample,
    output logic      done
);

    localparam logic [3:0] HALF_LAST = 4'(`ATW_SCLK_HALF - 1);

    logic       busy_q;
    logic       busy_d;
    logic       high_q;
    logic       high_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;

    always_comb begin
        busy_d = busy_q;
        high_d = high_q;
        cnt_d  = cnt_q;
        if (!busy_q) begin
            if (start) begin
                busy_d = 1'b1;
                high_d = 1'b1;
                cnt_d  = 4'h0;
            end
        end else if (cnt_q == HALF_LAST) begin
            cnt_d = 4'h0;
            if (high_q) begin
                high_d = 1'b0;
            end else begin
                busy_d = 1'b0;
            end
        end else begin
            cnt_d = cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            high_q <= 1'b0;
            cnt_q  <= 4'h0;
        end else begin
            busy_q <= busy_d;
            high_q <= high_d;
            cnt_q  <= cnt_d;
        end
    end

    // Sampling at the end of the high phase leaves the device and the
    // synchroniser a full half period to settle the new bit.
    assign sclk   = high_q;
    assign busy   = busy_q;
    assign sample = busy_q & high_q & (cnt_q == HALF_LAST);
    assign done   = busy_q & ~high_q & (cnt_q == HALF_LAST);

endmodule

// ==== rtl/atw_host_ctrl.sv ====
`timescale 1ns/100ps
`include "atw_map.svh"

// Overview of operation
// - Pulse input switch at ready falling edge
// - Optionally drop a late-switched first result
// - Keep serial clock low during power-up
// - Allow calibration request after stable power-up
// - Clock bits after ready low, MSB first
// - Finish reading before next data update
// - Two extra pulses request calibration
// - Keep clock quiet during calibration
// - Hold clock high after ready for sleep
// - Drive clock low to wake device
// - 25 bits before sleep calibrates on wake
// - Single conversions: wake, read, sleep again
// - Shared clock sleep and wake synchronises devices
// - Wait skew after first ready edge
module atw_host_ctrl #(
    parameter int unsigned POWERUP_CYCLES    = `ATW_POWERUP_MS * 1000 * `ATW_CLK_MHZ,
    parameter int unsigned SLEEP_HOLD_CYCLES = `ATW_SLEEP_HOLD_US * `ATW_CLK_MHZ
) (
    input  wire logic                    CLOCK,
    input  wire logic                    SYS_RST,
    input  wire logic                    READY_AND_SERIAL_OUT,
    input  wire logic                    CAL_REQUEST,
    input  wire logic                    SLEEP_REQUEST,
    input  wire logic                    SLEEP_WITH_CAL,
    input  wire logic                    SINGLE_MODE,
    input  wire logic                    WAKE_REQUEST,
    input  wire logic                    DISCARD_NEXT,
    output logic                         SCLK,
    output logic [`ATW_WORD_BITS-1:0]    RESULT,
    output logic                         RESULT_VALID,
    output logic                         POS_FULL_SCALE,
    output logic                         NEG_FULL_SCALE,
    output logic                         INPUT_SWITCH,
    output logic                         CALIBRATING,
    output logic                         SLEEPING,
    output logic                         POWERUP_TIMEOUT,
    output logic                         BUSY,
    output atw_pkg::atw_state_type       CTRL_STATE
);

    import atw_pkg::*;

    localparam int unsigned SKEW_CYCLES = `ATW_SKEW_US * `ATW_CLK_MHZ;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic count_hit(input logic [31:0] cnt, input int unsigned lim);
        count_hit = ({1'b0, cnt} + 33'h0_0000_0001) >= {1'b0, 32'(lim)};
    endfunction

    // ****************************************************************
    // Link synchronisation and pulse generation
    // ****************************************************************
    logic ready_s;
    logic gen_start;
    logic gen_sclk;
    logic gen_busy;
    logic gen_sample;
    logic gen_done;

    atw_sync2 u_sync (
        .clk (CLOCK),
        .rst (SYS_RST),
        .d   (READY_AND_SERIAL_OUT),
        .q   (ready_s)
    );

    atw_sclk_pulse u_pulse (
        .clk    (CLOCK),
        .rst    (SYS_RST),
        .start  (gen_start),
        .sclk   (gen_sclk),
        .busy   (gen_busy),
        .sample (gen_sample),
        .done   (gen_done)
    );

    // ****************************************************************
    // Controller state
    // ****************************************************************
    atw_state_type                state_q;
    atw_state_type                state_d;
    logic [31:0]                  wait_q;
    logic [31:0]                  wait_d;
    logic [4:0]                   bit_q;
    logic [4:0]                   bit_d;
    logic [1:0]                   extra_q;
    logic [1:0]                   extra_d;
    logic [`ATW_WORD_BITS-1:0]    shreg_q;
    logic [`ATW_WORD_BITS-1:0]    shreg_d;
    logic [`ATW_WORD_BITS-1:0]    result_q;
    logic [`ATW_WORD_BITS-1:0]    result_d;
    logic                         valid_q;
    logic                         valid_d;
    logic                         pos_q;
    logic                         pos_d;
    logic                         neg_q;
    logic                         neg_d;
    logic                         switch_q;
    logic                         switch_d;
    logic                         cal_q;
    logic                         cal_d;
    logic                         cal_pend_q;
    logic                         cal_pend_d;
    logic                         disc_q;
    logic                         disc_d;
    logic                         hold_q;
    logic                         hold_d;
    logic                         to_sleep_q;
    logic                         to_sleep_d;
    logic                         sleep_cal_q;
    logic                         sleep_cal_d;
    logic                         tmo_q;
    logic                         tmo_d;
    logic                         word_end;
    logic                         cal_take;
    logic                         want_sleep;

    assign word_end   = (state_q == ATW_ST_SHIFT) & gen_done & (bit_q == `ATW_WORD_LAST);
    assign want_sleep = SLEEP_REQUEST | SINGLE_MODE;
    assign cal_take   = word_end & cal_pend_q;

    // Pulses are only launched in the shift and extra states, so the clock stays quiet
    // during power-up, calibration and sleep.
    assign gen_start = ((state_q == ATW_ST_SHIFT) | (state_q == ATW_ST_EXTRA)) & ~gen_busy;

    always_comb begin
        state_d     = state_q;
        wait_d      = wait_q;
        bit_d       = bit_q;
        extra_d     = extra_q;
        shreg_d     = shreg_q;
        result_d    = result_q;
        valid_d     = 1'b0;
        pos_d       = pos_q;
        neg_d       = neg_q;
        switch_d    = 1'b0;
        cal_d       = cal_q;
        hold_d      = hold_q;
        to_sleep_d  = to_sleep_q;
        sleep_cal_d = sleep_cal_q;
        tmo_d       = tmo_q;
        // A new request in the cycle it is consumed stays pending.
        cal_pend_d  = CAL_REQUEST | (cal_pend_q & ~cal_take);
        disc_d      = DISCARD_NEXT | (disc_q & ~word_end);

        case (state_q)
            ATW_ST_POWERUP: begin
                // The line rises while the automatic calibration runs.
                wait_d = wait_q + 32'h0000_0001;
                if (ready_s) begin
                    cal_d   = 1'b1;
                    state_d = ATW_ST_WAIT_LOW;
                end else if (count_hit(wait_q, POWERUP_CYCLES)) begin
                    tmo_d   = 1'b1;
                    state_d = ATW_ST_WAIT_LOW;
                end
            end
            ATW_ST_WAIT_LOW: begin
                // Entered with the line high except after a power-up timeout, so a low level is the falling edge.
                wait_d = 32'h0000_0000;
                if (!ready_s) begin
                    switch_d = 1'b1;
                    cal_d    = 1'b0;
                    bit_d    = 5'h00;
                    if (want_sleep && !SINGLE_MODE) begin
                        hold_d      = 1'b1;
                        sleep_cal_d = 1'b0;
                        state_d     = ATW_ST_SLEEP_HOLD;
                    end else begin
                        state_d = ATW_ST_SKEW;
                    end
                end
            end
            ATW_ST_SKEW: begin
                // Other devices on the shared clock may lag by up to the skew.
                wait_d = wait_q + 32'h0000_0001;
                if (count_hit(wait_q, SKEW_CYCLES)) begin
                    state_d = ATW_ST_SHIFT;
                end
            end
            ATW_ST_SHIFT: begin
                if (gen_sample) begin
                    shreg_d = {shreg_q[`ATW_WORD_BITS-2:0], ready_s};
                end
                if (gen_done) begin
                    bit_d = bit_q + 5'h01;
                end
                if (word_end) begin
                    // The word is complete well before the next update at this rate.
                    if (!disc_q) begin
                        valid_d  = 1'b1;
                        result_d = shreg_d;
                        pos_d    = (shreg_d == `ATW_POS_FULL);
                        neg_d    = (shreg_d == `ATW_NEG_FULL);
                    end
                    if (cal_pend_q) begin
                        extra_d    = `ATW_CAL_EXTRA;
                        to_sleep_d = 1'b0;
                        cal_d      = 1'b1;
                        state_d    = ATW_ST_EXTRA;
                    end else if (want_sleep && SLEEP_WITH_CAL) begin
                        extra_d    = `ATW_POLL_EXTRA;
                        to_sleep_d = 1'b1;
                        state_d    = ATW_ST_EXTRA;
                    end else if (want_sleep) begin
                        // Without the 25th pulse the line keeps the last bit.
                        hold_d      = 1'b1;
                        sleep_cal_d = 1'b0;
                        wait_d      = 32'h0000_0000;
                        state_d     = ATW_ST_SLEEP_HOLD;
                    end else begin
                        extra_d    = `ATW_POLL_EXTRA;
                        to_sleep_d = 1'b0;
                        state_d    = ATW_ST_EXTRA;
                    end
                end
            end
            ATW_ST_EXTRA: begin
                if (gen_done) begin
                    extra_d = extra_q - 2'h1;
                    if (extra_q == 2'h1) begin
                        if (to_sleep_q) begin
                            hold_d      = 1'b1;
                            sleep_cal_d = 1'b1;
                            wait_d      = 32'h0000_0000;
                            state_d     = ATW_ST_SLEEP_HOLD;
                        end else begin
                            // The line is high now and falls at the next result.
                            state_d = ATW_ST_WAIT_LOW;
                        end
                    end
                end
            end
            ATW_ST_SLEEP_HOLD: begin
                wait_d = wait_q + 32'h0000_0001;
                if (count_hit(wait_q, SLEEP_HOLD_CYCLES)) begin
                    state_d = ATW_ST_SLEEP;
                end
            end
            ATW_ST_SLEEP: begin
                // A wake before the hold time would not have entered sleep.
                if (WAKE_REQUEST || !want_sleep) begin
                    hold_d  = 1'b0;
                    cal_d   = sleep_cal_q;
                    state_d = ATW_ST_WAIT_LOW;
                end
            end
            default: begin
                state_d = ATW_ST_POWERUP;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            state_q     <= ATW_ST_POWERUP;
            wait_q      <= 32'h0000_0000;
            bit_q       <= 5'h00;
            extra_q     <= 2'h0;
            shreg_q     <= `ATW_ZERO_WORD;
            result_q    <= `ATW_ZERO_WORD;
            valid_q     <= 1'b0;
            pos_q       <= 1'b0;
            neg_q       <= 1'b0;
            switch_q    <= 1'b0;
            cal_q       <= 1'b0;
            cal_pend_q  <= 1'b0;
            disc_q      <= 1'b0;
            hold_q      <= 1'b0;
            to_sleep_q  <= 1'b0;
            sleep_cal_q <= 1'b0;
            tmo_q       <= 1'b0;
        end else begin
            state_q     <= state_d;
            wait_q      <= wait_d;
            bit_q       <= bit_d;
            extra_q     <= extra_d;
            shreg_q     <= shreg_d;
            result_q    <= result_d;
            valid_q     <= valid_d;
            pos_q       <= pos_d;
            neg_q       <= neg_d;
            switch_q    <= switch_d;
            cal_q       <= cal_d;
            cal_pend_q  <= cal_pend_d;
            disc_q      <= disc_d;
            hold_q      <= hold_d;
            to_sleep_q  <= to_sleep_d;
            sleep_cal_q <= sleep_cal_d;
            tmo_q       <= tmo_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // The hold level and the pulse generator are never active together.
    assign SCLK            = gen_sclk | hold_q;
    assign RESULT          = result_q;
    assign RESULT_VALID    = valid_q;
    assign POS_FULL_SCALE  = pos_q;
    assign NEG_FULL_SCALE  = neg_q;
    assign INPUT_SWITCH    = switch_q;
    assign CALIBRATING     = cal_q;
    assign SLEEPING        = (state_q == ATW_ST_SLEEP);
    assign POWERUP_TIMEOUT = tmo_q;
    assign BUSY            = (state_q == ATW_ST_SHIFT) | (state_q == ATW_ST_EXTRA);
    assign CTRL_STATE      = state_q;

endmodule

// ==== testbench/atw_host_ctrl_props.sv ====
`timescale 1ns/100ps
`include "atw_map.svh"

module atw_host_ctrl_props #(
    parameter int unsigned SLEEP_HOLD_CYCLES = 50
) (
    input wire logic                      CLOCK,
    input wire logic                      SYS_RST,
    input wire logic                      WAKE_REQUEST,
    input wire logic                      SCLK,
    input wire logic [`ATW_WORD_BITS-1:0] RESULT,
    input wire logic                      RESULT_VALID,
    input wire logic                      POS_FULL_SCALE,
    input wire logic                      NEG_FULL_SCALE,
    input wire logic                      INPUT_SWITCH,
    input wire logic                      SLEEPING,
    input wire logic                      BUSY,
    input wire atw_pkg::atw_state_type    CTRL_STATE
);
    import atw_pkg::*;

    // ****************************************************************
    // Length of the current high level of the serial clock
    // ****************************************************************
    int unsigned hi_cnt_q;
    int unsigned hi_cnt_d;

    always_comb begin
        hi_cnt_d = SCLK ? hi_cnt_q + 1 : 0;
    end

    always_ff @(posedge CLOCK) begin
        hi_cnt_q <= SYS_RST ? 0 : hi_cnt_d;
    end

    default clocking dc @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);

    AST_POWERUP_QUIET: assert property (CTRL_STATE == ATW_ST_POWERUP |-> !SCLK)
        else $error("serial clock active during power-up");
    AST_WAIT_QUIET: assert property (CTRL_STATE == ATW_ST_WAIT_LOW |-> !SCLK)
        else $error("serial clock active while waiting for data ready");
    AST_SWITCH_STATE: assert property (INPUT_SWITCH |->
        CTRL_STATE inside {ATW_ST_SKEW, ATW_ST_SLEEP_HOLD})
        else $error("input switch pulse outside a ready fall");
    AST_SKEW_LEN: assert property ($rose(CTRL_STATE == ATW_ST_SKEW) |->
        ##249 (CTRL_STATE == ATW_ST_SKEW) ##1 (CTRL_STATE == ATW_ST_SHIFT))
        else $error("skew wait is not 250 cycles");
    AST_PULSE_SHAPE: assert property (BUSY && $rose(SCLK) |-> SCLK[*8] ##1 !SCLK[*8])
        else $error("serial clock pulse shape wrong");
    AST_SLEEP_HIGH: assert property (SLEEPING |-> SCLK)
        else $error("serial clock low while sleeping");
    AST_WAKE: assert property (SLEEPING && WAKE_REQUEST |=> !SCLK && !SLEEPING)
        else $error("wake request not served next cycle");
    // The hold starts from a low clock, so the run length is exactly the hold time.
    AST_HOLD_TIME: assert property ($rose(SLEEPING) |->
        hi_cnt_q == SLEEP_HOLD_CYCLES)
        else $error("sleep entered before hold time");
    AST_FLAGS: assert property (RESULT_VALID |->
        POS_FULL_SCALE == (RESULT == 24'h7f_ffff)
        && NEG_FULL_SCALE == (RESULT == 24'h80_0000))
        else $error("full-scale flags disagree with result");
    // The result and its valid pulse are registered on the same edge.
    AST_RESULT_HOLD: assert property (!RESULT_VALID |-> $stable(RESULT))
        else $error("result changed without valid");

    cover property ($rose(SLEEPING));
    cover property (RESULT_VALID && POS_FULL_SCALE);
    cover property (RESULT_VALID && NEG_FULL_SCALE);
endmodule

// ==== testbench/atw_dev_model.sv ====
`timescale 1ns/100ps

module atw_dev_model #(
    parameter int HOLD = 40
) (
    input wire logic clk,
    input wire logic sclk,
    output logic     ready_and_serial_out
);
    // ****************************************************************
    // Behavioural converter: shift, poll, calibrate, sleep
    // ****************************************************************
    logic [23:0] word_q;
    int          cnt_q;
    int          hi_cnt;
    logic        asleep;
    logic        cal_on_wake;
    logic        cal_started;

    initial begin
        word_q = 24'h00_0000;
        cnt_q = 0;
        hi_cnt = 0;
        asleep = 1'b0;
        cal_on_wake = 1'b0;
        cal_started = 1'b1;
        ready_and_serial_out = 1'b1;
    end

    // The testbench calls this for each new result; the line rises first to mark the update.
    task automatic present(input logic [23:0] w);
        ready_and_serial_out = 1'b1;
        #40;
        word_q = w;
        cnt_q = 0;
        cal_started = 1'b0;
        ready_and_serial_out = 1'b0;
    endtask

    always @(posedge sclk) begin
        if (!asleep) begin
            cnt_q = cnt_q + 1;
            if (cnt_q <= 24)
                ready_and_serial_out = word_q[24 - cnt_q];
            else
                ready_and_serial_out = 1'b1;
        end
    end

    always @(negedge sclk) begin
        if (asleep) begin
            asleep = 1'b0;
            cal_started = cal_on_wake;
        end else if (cnt_q == 26) begin
            cal_started = 1'b1;
        end
    end

    // The rising edge that starts the hold is counted too, so 25 full pulses read as 26.
    always @(posedge clk) begin
        hi_cnt = sclk ? hi_cnt + 1 : 0;
        if (hi_cnt == HOLD) begin
            asleep = 1'b1;
            cal_on_wake = (cnt_q >= 26);
            ready_and_serial_out = 1'b1;
        end
    end
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
`include "atw_map.svh"

module testbench;
    import atw_pkg::*;

    logic                      clk;
    logic                      rst;
    logic                      line;
    logic                      cal_req;
    logic                      sleep_req;
    logic                      sleep_cal;
    logic                      single;
    logic                      wake;
    logic                      discard;
    logic                      sclk;
    logic [`ATW_WORD_BITS-1:0] result;
    logic                      valid;
    logic                      pos_fs;
    logic                      neg_fs;
    logic                      in_sw;
    logic                      calib;
    logic                      sleeping;
    logic                      busy;
    logic                      tmo;
    atw_state_type             state;
    int                        err_total;
    int                        samples_checked;
    int                        pulses;

    atw_host_ctrl #(.POWERUP_CYCLES(200), .SLEEP_HOLD_CYCLES(50)) atw_host_ctrl_inst (
        .CLOCK(clk), .SYS_RST(rst), .READY_AND_SERIAL_OUT(line), .CAL_REQUEST(cal_req),
        .SLEEP_REQUEST(sleep_req), .SLEEP_WITH_CAL(sleep_cal), .SINGLE_MODE(single),
        .WAKE_REQUEST(wake), .DISCARD_NEXT(discard), .SCLK(sclk), .RESULT(result),
        .RESULT_VALID(valid), .POS_FULL_SCALE(pos_fs), .NEG_FULL_SCALE(neg_fs),
        .INPUT_SWITCH(in_sw), .CALIBRATING(calib), .SLEEPING(sleeping),
        .POWERUP_TIMEOUT(tmo), .BUSY(busy), .CTRL_STATE(state));

    atw_dev_model #(.HOLD(40)) dev_inst (.clk(clk), .sclk(sclk), .ready_and_serial_out(line));

    always #4 clk = ~clk;
    always @(posedge sclk) pulses++;

    // ****************************************************************
    // Shared helpers
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic do_word(input logic [23:0] w, input logic expv);
        int   sw;
        logic got;
        sw = 0;
        got = 1'b0;
        pulses = 0;
        dev_inst.present(w);
        for (int n = 0; n < 1200 && !got; n++) begin
            step(1);
            sw += (in_sw === 1'b1);
            got = (valid === 1'b1);
        end
        chk("input_switch", 1, sw);
        chk("result_valid", expv, got);
        if (expv) begin
            chk("result", w, result);
            chk("pos_full", w == 24'h7f_ffff, pos_fs);
            chk("neg_full", w == 24'h80_0000, neg_fs);
        end
        for (int n = 0; n < 60 && busy !== 1'b0; n++)
            step(1);
    endtask

    task automatic sleep_wake(input logic exp_cal);
        for (int n = 0; n < 400 && sleeping !== 1'b1; n++)
            step(1);
        chk("sleeping", 1, sleeping);
        chk("dev_asleep", 1, dev_inst.asleep);
        chk("line_asleep", 1, line);
        wake = 1'b1;
        sleep_req = 1'b0;
        single = 1'b0;
        sleep_cal = 1'b0;
        step(1);
        wake = 1'b0;
        step(1);
        chk("sclk_wake", 0, sclk);
        chk("calibrating", exp_cal, calib);
        chk("dev_cal", exp_cal, dev_inst.cal_started);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_powerup();
        step(3);
        chk("cal_powerup", 1, calib);
        chk("sclk_powerup", 0, sclk);
        chk("powerup_tmo", 0, tmo);
        do_word(24'h7f_ffff, 1);
        chk("cal_done", 0, calib);
    endtask

    task automatic t_codes();
        logic [23:0] codes [4] = '{24'h00_0001, 24'hff_ffff, 24'h00_0000, 24'h80_0000};
        foreach (codes[i]) begin
            do_word(codes[i], 1);
            chk("poll_pulses", 25, pulses);
            chk("poll_line", 1, line);
        end
    endtask

    task automatic t_cal();
        cal_req = 1'b1;
        step(1);
        cal_req = 1'b0;
        do_word(24'h12_3456, 1);
        chk("cal_pulses", 26, pulses);
        chk("cal_dev", 1, dev_inst.cal_started);
        chk("cal_flag", 1, calib);
        step(20);
        chk("cal_quiet", 26, pulses);
        do_word(24'h65_4321, 1);
        chk("cal_end", 0, calib);
    endtask

    task automatic t_discard();
        discard = 1'b1;
        step(1);
        discard = 1'b0;
        do_word(24'h0f_0f0f, 0);
        do_word(24'h0a_0a0a, 1);
    endtask

    task automatic t_sleep();
        sleep_req = 1'b1;
        dev_inst.present(24'h11_1111);
        sleep_wake(0);
        do_word(24'h22_2222, 1);
    endtask

    task automatic t_single();
        single = 1'b1;
        sleep_req = 1'b1;
        sleep_cal = 1'b1;
        do_word(24'h33_3333, 1);
        sleep_wake(1);
        do_word(24'h44_4444, 1);
        chk("cal_after_wake", 0, calib);
        // Sleep straight after 24 bits must not ask for a calibration on wake.
        single = 1'b1;
        do_word(24'h55_5555, 1);
        sleep_wake(0);
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {cal_req, sleep_req, sleep_cal, single, wake, discard} = 6'h00;
        err_total = 0;
        samples_checked = 0;
        pulses = 0;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        t_powerup();
        t_codes();
        t_cal();
        t_discard();
        t_sleep();
        t_single();
        report_and_stop();
    end

    // Roughly fifteen words of about 700 cycles each; this leaves ample margin.
    initial begin
        #300_000;
        err_total++;
        report_and_stop();
    end
endmodule

bind atw_host_ctrl atw_host_ctrl_props #(.SLEEP_HOLD_CYCLES(SLEEP_HOLD_CYCLES)) props_inst (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .WAKE_REQUEST(WAKE_REQUEST), .SCLK(SCLK),
    .RESULT(RESULT), .RESULT_VALID(RESULT_VALID), .POS_FULL_SCALE(POS_FULL_SCALE),
    .NEG_FULL_SCALE(NEG_FULL_SCALE), .INPUT_SWITCH(INPUT_SWITCH), .SLEEPING(SLEEPING),
    .BUSY(BUSY), .CTRL_STATE(CTRL_STATE));
